// ==== design/tsev_flags.sv ====
// status flags and software event generation of an advanced control timer
// assumes the counter core supplies counter value, overflow/underflow strobes and
// repetition state on clk_sys_i; break and channel pins are asynchronous
// Operation
// - output channel flag rises when counter equals its compare value
// - compare above reload sets flag at overflow, or underflow when counting down edge-aligned
// - input channel flag rises on capture from selected input edge
// - channel flag clears on write zero, or capture read in input mode
// - status flags clear on written zero, written one leaves them alone
// - overcapture flag set only in input mode when capture hits set flag
// - channels five and six flags at bits 16 and 17, compare only
// - system break flag set on input active, clear only when inactive
// - second break flag set on input active, clear only when inactive
// - break flag set on input active, clear only when inactive
// - trigger flag on trigger edge, or counter start/stop in gated mode
// - commutation flag set on commutation transfer, software clears it
// - update flag at overflow/underflow if repetition zero and not disabled
// - update flag on software or trigger reinit if source and disable zero
// - generation bits act on written one, self clear, zero does nothing
// - second break force clears main output enable and sets its flag
// - break force clears main output enable and sets break flag
// - trigger force sets trigger flag
// - commutation force transfers control bits only with preload select set
// - channel force sets flag; input channel captures and may set overrun
// - update force reloads counter to zero or reload value, clears prescaler
// - each flag requests interrupt only with its enable bit set; overcapture and channel five and six flags never do
`timescale 1ns/1ps
`include "tsev_regs.svh"

module tsev_flags
  import tsev_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int N_IN  = 4,
  parameter int N_CH  = 6
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // counter core
  input  wire logic [CNT_W-1:0]      counter_value_i,
  input  wire logic [CNT_W-1:0]      auto_reload_value_i,
  input  wire logic [N_CH*CNT_W-1:0] channel_compare_value_i,
  input  wire logic                  cnt_overflow_i,
  input  wire logic                  cnt_underflow_i,
  input  wire logic                  rep_zero_i,
  input  wire logic                  cnt_running_i,
  input  wire logic                  trigger_input_edge_i,
  input  wire logic                  trigger_reinit_i,
  input  wire logic                  commutation_done_i,
  // pins
  input  wire logic [N_IN-1:0]       channel_pin_i,
  input  wire logic                  break_pin_i,
  input  wire logic                  second_break_pin_i,
  input  wire logic                  system_break_pin_i,
  // actions toward the rest of the timer
  output logic                       irq_o,
  output logic                       main_output_enable_clr_o,
  output logic                       pwm_hold_o,
  output logic                       commutation_xfer_o,
  output logic                       counter_reload_o,
  output logic      [CNT_W-1:0]      counter_reload_val_o,
  output logic                       prescaler_clr_o
);

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_flags = reg_wr_i && hit(reg_addr_i, `TSEV_FLAGS_OFS);
  wire wr_gen   = reg_wr_i && hit(reg_addr_i, `TSEV_GEN_OFS);
  wire wr_ie    = reg_wr_i && hit(reg_addr_i, `TSEV_IRQ_EN_OFS);
  wire wr_ctrl  = reg_wr_i && hit(reg_addr_i, `TSEV_CTRL_OFS);

  // ****************************************************************
  // control and enable registers
  // ****************************************************************
  logic [`TSEV_CTRL_W-1:0] ctrl_q;
  logic [`TSEV_IE_W-1:0]   ie_q;
  logic [`TSEV_GEN_W-1:0]  gen_q;

  // generation bits live one cycle and clear themselves; the generation word is not in the read mux, so it reads as zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `TSEV_CTRL_RST;
      ie_q   <= `TSEV_IE_RST;
      gen_q  <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata_i[`TSEV_CTRL_W-1:0];
      if (wr_ie)   ie_q   <= reg_wdata_i[`TSEV_IE_W-1:0];
      gen_q <= wr_gen ? reg_wdata_i[`TSEV_GEN_W-1:0] : '0;
    end
  end


  // fields of the control word
  wire             update_disable     = ctrl_q[`TSEV_CTRL_UPDATE_DISABLE_BIT];
  wire             update_request_source      = ctrl_q[`TSEV_CTRL_URS_BIT];
  wire             control_preload_select     = ctrl_q[`TSEV_CTRL_CONTROL_PRELOAD_SELECT_BIT];
  wire             cnt_down = ctrl_q[`TSEV_CTRL_DOWN_BIT];
  wire [1:0]       center_align_select      = ctrl_q[`TSEV_CTRL_CMS_MSB:`TSEV_CTRL_CMS_LSB];
  wire [N_IN-1:0]  in_mode  = ctrl_q[`TSEV_CTRL_IN_MSB:`TSEV_CTRL_IN_LSB];
  wire [N_IN-1:0]  in_fall  = ctrl_q[`TSEV_CTRL_POL_MSB:`TSEV_CTRL_POL_LSB];
  tsev_sms_t       sms;
  assign sms = tsev_sms_t'(ctrl_q[`TSEV_CTRL_SMS_MSB:`TSEV_CTRL_SMS_LSB]);


  // one-cycle strobes; a repeated write repeats the event
  wire g_upd  = gen_q[`TSEV_GEN_UPD_BIT];
  wire g_com  = gen_q[`TSEV_GEN_COM_BIT];
  wire g_trg  = gen_q[`TSEV_GEN_TRG_BIT];
  wire g_brk  = gen_q[`TSEV_GEN_BRK_BIT];
  wire g_brk2 = gen_q[`TSEV_GEN_BRK2_BIT];
  wire [N_IN-1:0] g_ch = gen_q[`TSEV_GEN_CH1_BIT +: N_IN];

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  // channel pins low, then break, break 2, system break
  localparam int NP = N_IN + 3;
  logic [NP-1:0] pin_s1_q, pin_s2_q, pin_prev_q;

  // second stage feeds the edge logic; the first stage is read by nothing else
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_s1_q   <= {system_break_pin_i, second_break_pin_i, break_pin_i, channel_pin_i};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  wire [NP-1:0] pin_rise = pin_s2_q & ~pin_prev_q;
  wire [NP-1:0] pin_fall = ~pin_s2_q & pin_prev_q;
  wire brk_lvl  = pin_s2_q[N_IN];
  wire brk2_lvl = pin_s2_q[N_IN+1];
  wire sbrk_lvl = pin_s2_q[N_IN+2];


  // ****************************************************************
  // channel flags, captures and overruns
  // ****************************************************************
  logic [N_CH-1:0]            ch_flag_q;
  logic [N_IN-1:0]            ovr_q;
  logic [N_IN-1:0][CNT_W-1:0] cap_q;
  logic [N_CH-1:0]            eq_prev_q;
  logic [N_CH-1:0]            ch_set;
  logic [N_CH-1:0]            ch_clr;
  logic [N_IN-1:0]            cap_evt;
  logic [N_IN-1:0]            cap_rd;

  // overflow in up and centre-aligned counting, underflow only in plain down counting
  wire wrap_evt = (center_align_select == `TSEV_CMS_EDGE && cnt_down) ? cnt_underflow_i
                                                       : cnt_overflow_i;


  // channels past N_IN are compare only
  genvar i;
  generate
    for (i = 0; i < N_CH; i++) begin : g_ch_flag
      localparam int FB = (i < N_IN) ? (`TSEV_CH1_BIT + i)
                                     : (`TSEV_CH5_BIT + i - N_IN);
      wire [CNT_W-1:0] cmp    = channel_compare_value_i[i*CNT_W +: CNT_W];
      wire             is_in  = (i < N_IN) ? in_mode[i % N_IN] : 1'b0;
      wire             eq_now = (counter_value_i == cmp);
      wire             above  = (cmp > auto_reload_value_i);
      // equality is edge-detected so a stopped counter sets the flag only once
      wire             out_hit = !is_in && ((eq_now && !eq_prev_q[i])
                                 || (above && wrap_evt));
      wire             force_hit = (i < N_IN) ? g_ch[i % N_IN] : 1'b0;

      if (i < N_IN) begin : g_in
        wire edge_hit = in_fall[i] ? pin_fall[i] : pin_rise[i];
        assign cap_evt[i] = in_mode[i] && (edge_hit || g_ch[i]);
        assign cap_rd[i]  = reg_rd_i && in_mode[i]
                            && hit(reg_addr_i, 8'(`TSEV_CAP_BASE_OFS + 4 * i));

        // capture the counter; a capture over a pending flag marks an overrun
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            cap_q[i] <= '0;
            ovr_q[i] <= 1'b0;
          end else begin
            if (cap_evt[i]) cap_q[i] <= counter_value_i;
            if (cap_evt[i] && ch_flag_q[i]) ovr_q[i] <= 1'b1;
            else if (wr_flags && !reg_wdata_i[`TSEV_OVR1_BIT + i]) ovr_q[i] <= 1'b0;
          end
        end
      end

      assign ch_set[i] = out_hit || force_hit || ((i < N_IN) ? cap_evt[i % N_IN] : 1'b0);
      assign ch_clr[i] = (wr_flags && !reg_wdata_i[FB])
                         || ((i < N_IN) ? cap_rd[i % N_IN] : 1'b0);

      // a set in the same cycle as a clear wins
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ch_flag_q[i] <= 1'b0;
          eq_prev_q[i] <= 1'b0;
        end else begin
          eq_prev_q[i] <= eq_now;
          if (ch_set[i])      ch_flag_q[i] <= 1'b1;
          else if (ch_clr[i]) ch_flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // update, trigger, commutation and break flags
  // ****************************************************************
  logic upd_q, trg_q, com_q, brk_q, brk2_q, sbrk_q, run_prev_q;


  // only the flag is gated; the reload still goes out
  wire upd_set  = ((cnt_overflow_i || cnt_underflow_i) && rep_zero_i && !update_disable)
                  || ((g_upd || trigger_reinit_i) && !update_request_source && !update_disable);
  wire gated    = (sms == TSEV_SMS_GATED);
  wire trg_set  = (sms != TSEV_SMS_OFF && !gated && trigger_input_edge_i)
                  || (gated && (cnt_running_i != run_prev_q))
                  || g_trg;

  wire com_fire = g_com && control_preload_select;
  wire com_set  = commutation_done_i || com_fire;

  wire brk_set  = pin_rise[N_IN] || g_brk;
  wire brk2_set = pin_rise[N_IN+1] || g_brk2;
  wire sbrk_set = pin_rise[N_IN+2];

  // break clears are refused while the break input is still active
  wire clr_upd  = wr_flags && !reg_wdata_i[`TSEV_UPD_BIT];
  wire clr_trg  = wr_flags && !reg_wdata_i[`TSEV_TRG_BIT];
  wire clr_com  = wr_flags && !reg_wdata_i[`TSEV_COM_BIT];
  wire clr_brk  = wr_flags && !reg_wdata_i[`TSEV_BRK_BIT] && !brk_lvl;
  wire clr_brk2 = wr_flags && !reg_wdata_i[`TSEV_BRK2_BIT] && !brk2_lvl;
  wire clr_sbrk = wr_flags && !reg_wdata_i[`TSEV_SBRK_BIT] && !sbrk_lvl;

  // each flag: set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_q      <= 1'b0;
      trg_q      <= 1'b0;
      com_q      <= 1'b0;
      brk_q      <= 1'b0;
      brk2_q     <= 1'b0;
      sbrk_q     <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= cnt_running_i;
      upd_q  <= upd_set  || (upd_q  && !clr_upd);
      trg_q  <= trg_set  || (trg_q  && !clr_trg);
      com_q  <= com_set  || (com_q  && !clr_com);
      brk_q  <= brk_set  || (brk_q  && !clr_brk);
      brk2_q <= brk2_set || (brk2_q && !clr_brk2);
      sbrk_q <= sbrk_set || (sbrk_q && !clr_sbrk);
    end
  end

  // ****************************************************************
  // actions toward the counter and output stages
  // ****************************************************************
  // registered one cycle after the generation pulse so the outputs stay flop-driven
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_output_enable_clr_o <= 1'b0;
      commutation_xfer_o       <= 1'b0;
      counter_reload_o         <= 1'b0;
      counter_reload_val_o     <= '0;
      prescaler_clr_o          <= 1'b0;
    end else begin
      main_output_enable_clr_o <= g_brk || g_brk2;
      commutation_xfer_o       <= com_fire;
      counter_reload_o         <= g_upd;
      prescaler_clr_o          <= g_upd;
      if (g_upd)
        counter_reload_val_o <= (center_align_select == `TSEV_CMS_EDGE && cnt_down)
                                ? auto_reload_value_i : '0;
    end
  end

  // pwm stays parked while the system break flag is pending
  // limitation: follows the flag, not the live input
  assign pwm_hold_o = sbrk_q;


  // ****************************************************************
  // interrupt request
  // ****************************************************************
  // channels five and six have no enable bit, so they never reach the line
  // all three break sources share one enable

  wire irq_brk = (brk_q || brk2_q || sbrk_q) && ie_q[`TSEV_IE_BRK_BIT];
  assign irq_o = (upd_q && ie_q[`TSEV_IE_UPD_BIT])
                 || (|(ch_flag_q[N_IN-1:0] & ie_q[`TSEV_IE_CH1_BIT +: N_IN]))
                 || (com_q && ie_q[`TSEV_IE_COM_BIT])
                 || (trg_q && ie_q[`TSEV_IE_TRG_BIT])
                 || irq_brk;

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] flags_word;
  logic [31:0] rd_mux;
  always_comb begin
    flags_word = '0;
    flags_word[`TSEV_UPD_BIT]          = upd_q;
    flags_word[`TSEV_CH1_BIT +: N_IN]  = ch_flag_q[N_IN-1:0];
    flags_word[`TSEV_COM_BIT]          = com_q;
    flags_word[`TSEV_TRG_BIT]          = trg_q;
    flags_word[`TSEV_BRK_BIT]          = brk_q;
    flags_word[`TSEV_BRK2_BIT]         = brk2_q;
    flags_word[`TSEV_OVR1_BIT +: N_IN] = ovr_q;
    flags_word[`TSEV_SBRK_BIT]         = sbrk_q;
    flags_word[`TSEV_CH5_BIT]          = ch_flag_q[N_IN];
    flags_word[`TSEV_CH6_BIT]          = ch_flag_q[N_IN+1];

    // offsets never overlap, so order is free
    rd_mux = '0;
    if (hit(reg_addr_i, `TSEV_FLAGS_OFS))   rd_mux = flags_word;
    if (hit(reg_addr_i, `TSEV_IRQ_EN_OFS))  rd_mux = 32'(ie_q);
    if (hit(reg_addr_i, `TSEV_CTRL_OFS))    rd_mux = 32'(ctrl_q);
    for (int k = 0; k < N_IN; k++) begin
      if (hit(reg_addr_i, 8'(`TSEV_CAP_BASE_OFS + 4 * k))) rd_mux = 32'(cap_q[k]);
    end
  end

  // the generation word and unmapped addresses read as zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) reg_rdata_o <= '0;
    else          reg_rdata_o <= reg_rd_i ? rd_mux : '0;
  end

endmodule : tsev_flags

// ==== design/tsev_pkg.sv ====
// types shared by the timer status and event block
// assumes tsev_regs.svh is compiled alongside
package tsev_pkg;

  // slave mode codes as seen by the flag logic
  typedef enum logic [3:0] {
    TSEV_SMS_OFF    = 4'b0000,
    TSEV_SMS_ENC1   = 4'b0001,
    TSEV_SMS_ENC2   = 4'b0010,
    TSEV_SMS_ENC3   = 4'b0011,
    TSEV_SMS_RESET  = 4'b0100,
    TSEV_SMS_GATED  = 4'b0101,
    TSEV_SMS_TRIG   = 4'b0110,
    TSEV_SMS_EXTCLK = 4'b0111,
    TSEV_SMS_RSTTRG = 4'b1000
  } tsev_sms_t;

endpackage : tsev_pkg

// ==== design/tsev_regs.svh ====
// register offsets, field positions and reset values of the timer status and event block
// assumes a byte-addressed register port with one 32-bit word per register
`ifndef TSEV_REGS_SVH
`define TSEV_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TSEV_IRQ_EN_OFS      8'h0C
`define TSEV_FLAGS_OFS       8'h10
`define TSEV_GEN_OFS         8'h14
`define TSEV_CAP_BASE_OFS    8'h34
`define TSEV_CTRL_OFS        8'h60

// ****************************************************************
// status flag positions
// ****************************************************************
`define TSEV_UPD_BIT         0
`define TSEV_CH1_BIT         1
`define TSEV_COM_BIT         5
`define TSEV_TRG_BIT         6
`define TSEV_BRK_BIT         7
`define TSEV_BRK2_BIT        8
`define TSEV_OVR1_BIT        9
`define TSEV_SBRK_BIT        13
`define TSEV_CH5_BIT         16
`define TSEV_CH6_BIT         17

// ****************************************************************
// event generation bit positions
// ****************************************************************
`define TSEV_GEN_UPD_BIT     0
`define TSEV_GEN_CH1_BIT     1
`define TSEV_GEN_COM_BIT     5
`define TSEV_GEN_TRG_BIT     6
`define TSEV_GEN_BRK_BIT     7
`define TSEV_GEN_BRK2_BIT    8
`define TSEV_GEN_W           9

// ****************************************************************
// interrupt enable fields
// ****************************************************************
`define TSEV_IE_W            8
`define TSEV_IE_UPD_BIT      0
`define TSEV_IE_CH1_BIT      1
`define TSEV_IE_COM_BIT      5
`define TSEV_IE_TRG_BIT      6
`define TSEV_IE_BRK_BIT      7

// ****************************************************************
// control register fields
// ****************************************************************
`define TSEV_CTRL_UPDATE_DISABLE_BIT   0
`define TSEV_CTRL_URS_BIT    1
`define TSEV_CTRL_CONTROL_PRELOAD_SELECT_BIT   2
`define TSEV_CTRL_DOWN_BIT   3
`define TSEV_CTRL_CMS_LSB    4
`define TSEV_CTRL_CMS_MSB    5
`define TSEV_CTRL_IN_LSB     6
`define TSEV_CTRL_IN_MSB     9
`define TSEV_CTRL_POL_LSB    10
`define TSEV_CTRL_POL_MSB    13
`define TSEV_CTRL_SMS_LSB    14
`define TSEV_CTRL_SMS_MSB    17
`define TSEV_CTRL_W          18

// ****************************************************************
// reset values
// ****************************************************************
`define TSEV_CTRL_RST        18'h00000
`define TSEV_IE_RST          8'h00
`define TSEV_CMS_EDGE        2'h0

`endif

// ==== dv/tsev_flags_tb_top.sv ====
// self-checking bench for tsev_flags: register tasks and scenario sequences
// assumes tsev_monitor binds itself and the register map of tsev_regs.svh
`timescale 1ns/1ps
`include "tsev_regs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end

module tsev_flags_tb_top
  import tsev_pkg::*;
;
  localparam logic [7:0]  FL = `TSEV_FLAGS_OFS;
  localparam logic [7:0]  GN = `TSEV_GEN_OFS;
  localparam logic [7:0]  CT = `TSEV_CTRL_OFS;
  localparam logic [7:0]  IE = `TSEV_IRQ_EN_OFS;
  localparam logic [31:0] BM [3] = '{32'h80, 32'h100, 32'h2000};
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [15:0] counter_value_i = 16'h0001, auto_reload_value_i = 16'h0100;
  logic [95:0] channel_compare_value_i = {6{16'h0080}};
  logic        rep_zero_i = 1'b0, cnt_running_i = 1'b0;
  logic [4:0]  pls = 5'h00;  // ovf, unf, trig edge, trig reinit, commutation done
  logic [2:0]  brk = 3'h0;   // break, second break, system break
  logic [3:0]  channel_pin_i = 4'h0;
  logic        irq_o, main_output_enable_clr_o, pwm_hold_o, commutation_xfer_o;
  logic        counter_reload_o, prescaler_clr_o;
  logic [15:0] counter_reload_val_o;
  int          err_total = 0, checks = 0, cyc = 0;

  tsev_flags uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .counter_value_i(counter_value_i),
    .auto_reload_value_i(auto_reload_value_i), .channel_compare_value_i(channel_compare_value_i),
    .cnt_overflow_i(pls[0]), .cnt_underflow_i(pls[1]), .rep_zero_i(rep_zero_i),
    .cnt_running_i(cnt_running_i), .trigger_input_edge_i(pls[2]), .trigger_reinit_i(pls[3]),
    .commutation_done_i(pls[4]), .channel_pin_i(channel_pin_i), .break_pin_i(brk[0]),
    .second_break_pin_i(brk[1]), .system_break_pin_i(brk[2]), .irq_o(irq_o),
    .main_output_enable_clr_o(main_output_enable_clr_o), .pwm_hold_o(pwm_hold_o),
    .commutation_xfer_o(commutation_xfer_o), .counter_reload_o(counter_reload_o),
    .counter_reload_val_o(counter_reload_val_o), .prescaler_clr_o(prescaler_clr_o)
  );

  // 200 MHz clock; the cycle ceiling catches a hang
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  // ****************************************************************
  // register port and stimulus tasks
  // ****************************************************************
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc_n
  // the trailing delay lets the written register settle before a port check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata_o)
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    pls[k] <= 1'b1;
    @(posedge clk_sys_i);
    pls[k] <= 1'b0;
    cyc_n(2);
  endtask : pulse
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    cyc_n(8);
    rst_n_i <= 1'b1;
    rd(FL, 32'h0, "flags_rst");
    rd(GN, 32'h0, "gen_read");
    rd(8'h20, 32'h0, "unmapped");
    wr(IE, 32'hFF);
    wr(GN, 32'h1);
    rd(FL, 32'h1, "upd_force");
    `CHK("reload_up", 16'h0000, counter_reload_val_o)
    wr(FL, 32'hFFFFFFFF);
    rd(FL, 32'h1, "w1_keep");
    `CHK("irq_on", 1'b1, irq_o)
    wr(IE, 32'hFE);
    `CHK("irq_mask", 1'b0, irq_o)
    wr(FL, 32'h0);
    rd(FL, 32'h0, "w0_clear");
    // update flag gated by disable and request source; reload still happens
    wr(CT, 32'h9);
    wr(GN, 32'h1);
    rd(FL, 32'h0, "upd_dis");
    `CHK("reload_down", auto_reload_value_i, counter_reload_val_o)
    wr(CT, 32'h2);
    wr(GN, 32'h1);
    rd(FL, 32'h0, "upd_urs");
    wr(CT, 32'h0);
    pulse(3);
    rd(FL, 32'h1, "upd_trig");
    for (int z = 0; z < 2; z++) begin
      wr(FL, 32'h0);
      cyc_n(1);
      rep_zero_i <= z[0];
      pulse(0);
      rd(FL, {31'h0, z[0]}, "upd_ovf");
    end
    // compare match on ch1 and ch5, ch2 above reload fires at overflow
    wr(FL, 32'h0);
    cyc_n(1);
    channel_compare_value_i[15:0] <= 16'h0010;
    channel_compare_value_i[31:16] <= 16'h0200;
    channel_compare_value_i[79:64] <= 16'h0010;
    cyc_n(1);
    counter_value_i <= 16'h0010;
    cyc_n(3);
    rd(FL, 32'h00010002, "cmp_match");
    wr(FL, 32'h0);
    pulse(0);
    rd(FL, 32'h5, "cmp_above");
    wr(FL, 32'h0);
    wr(GN, 32'h2);
    wr(GN, 32'h2);
    rd(FL, 32'h2, "force_out");
    // ch1 as input: two captures overrun, capture read clears only the flag
    wr(FL, 32'h0);
    wr(CT, 32'h40);
    cyc_n(1);
    counter_value_i <= 16'h0055;
    for (int i = 0; i < 2; i++) begin
      cyc_n(1);
      channel_pin_i <= 4'h1;
      cyc_n(4);
      channel_pin_i <= 4'h0;
      cyc_n(6);
    end
    rd(FL, 32'h202, "capture");
    rd(8'h34, 32'h55, "cap_val");
    rd(FL, 32'h200, "cap_rd_clr");
    wr(FL, 32'h0);
    wr(GN, 32'h2);
    wr(GN, 32'h2);
    rd(FL, 32'h202, "force_in");
    // trigger flag: gated mode ignores edges and reacts to start
    wr(FL, 32'h0);
    wr(CT, 32'(TSEV_SMS_GATED) << 14);
    pulse(2);
    rd(FL, 32'h0, "gated_edge");
    cyc_n(1);
    cnt_running_i <= 1'b1;
    cyc_n(3);
    rd(FL, 32'h40, "gated_start");
    wr(FL, 32'h0);
    wr(CT, 32'(TSEV_SMS_TRIG) << 14);
    pulse(2);
    rd(FL, 32'h40, "trig_edge");
    wr(FL, 32'h0);
    wr(GN, 32'h40);
    rd(FL, 32'h40, "trig_force");
    // commutation force needs preload select; external transfer also flags
    wr(FL, 32'h0);
    wr(GN, 32'h20);
    rd(FL, 32'h0, "com_nopre");
    wr(CT, 32'h4);
    wr(GN, 32'h20);
    rd(FL, 32'h20, "com_force");
    wr(FL, 32'h0);
    pulse(4);
    rd(FL, 32'h20, "com_ext");
    // break inputs: a clear is refused while the input stays active
    wr(FL, 32'h0);
    for (int b = 0; b < 3; b++) begin
      cyc_n(1);
      brk[b] <= 1'b1;
      cyc_n(8);
      wr(FL, 32'h0);
      rd(FL, BM[b], "brk_hold");
      `CHK("brk_irq", 1'b1, irq_o)
      `CHK("pwm_hold", (b == 2), pwm_hold_o)
      cyc_n(1);
      brk[b] <= 1'b0;
      cyc_n(8);
      wr(FL, 32'h0);
      rd(FL, 32'h0, "brk_clr");
    end
    wr(GN, 32'h80);
    rd(FL, 32'h80, "brk_force");
    wr(FL, 32'h0);
    wr(GN, 32'h100);
    rd(FL, 32'h100, "brk2_force");
    summarize();
  end
endmodule : tsev_flags_tb_top

// ==== dv/tsev_monitor.sv ====
// concurrent checks on the ports of the timer status and event block
// assumes one clock domain and the register map of tsev_regs.svh
`timescale 1ns/1ps
`include "tsev_regs.svh"

module tsev_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        system_break_pin_i,
  input wire logic        main_output_enable_clr_o,
  input wire logic        pwm_hold_o,
  input wire logic        commutation_xfer_o,
  input wire logic        counter_reload_o,
  input wire logic        prescaler_clr_o
);
  // decoded software writes to generation and flag registers
  wire gen_wr  = reg_wr_i && (reg_addr_i == `TSEV_GEN_OFS);
  wire flag_wr = reg_wr_i && (reg_addr_i == `TSEV_FLAGS_OFS);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************************************
  // generated events reach the action outputs two cycles on
  // ****************************************************************
  a_break_force_moe: assert property (gen_wr && reg_wdata_i[7] |-> ##2 main_output_enable_clr_o)
    else $error("break force did not clear output enable");
  a_brk2_force_moe: assert property (gen_wr && reg_wdata_i[8] |-> ##2 main_output_enable_clr_o)
    else $error("second break force did not clear output enable");
  a_update_force_reload: assert property (gen_wr && reg_wdata_i[0] |-> ##2 counter_reload_o)
    else $error("update force did not reload counter");
  a_update_force_presc: assert property (gen_wr && reg_wdata_i[0] |-> ##2 prescaler_clr_o)
    else $error("update force did not clear prescaler");
  // a transfer without a commutation force two cycles before is spurious
  a_com_xfer_cause: assert property (commutation_xfer_o |-> $past(gen_wr && reg_wdata_i[5], 2))
    else $error("commutation transfer without force");
  a_gen_reads_zero: assert property (reg_rd_i && reg_addr_i == `TSEV_GEN_OFS |=> reg_rdata_o == 32'h0)
    else $error("generation register read nonzero");

  // ****************************************************************
  // system break holds pwm until cleared with the input inactive
  // ****************************************************************
  a_sysbrk_sets_hold: assert property (system_break_pin_i [*6] |-> pwm_hold_o)
    else $error("system break did not hold pwm");
  a_sysbrk_clear_cause: assert property ($fell(pwm_hold_o) |-> $past(flag_wr && !reg_wdata_i[13]))
    else $error("pwm hold dropped without software clear");

  c_update_force: cover property (gen_wr && reg_wdata_i[0]);
  c_com_xfer: cover property (commutation_xfer_o);
  c_hold_release: cover property ($fell(pwm_hold_o));
endmodule : tsev_monitor

bind tsev_flags tsev_monitor u_mon (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .system_break_pin_i(system_break_pin_i),
  .main_output_enable_clr_o(main_output_enable_clr_o), .pwm_hold_o(pwm_hold_o),
  .commutation_xfer_o(commutation_xfer_o), .counter_reload_o(counter_reload_o),
  .prescaler_clr_o(prescaler_clr_o)
);
